/* core/vstc_defines.vh */
// Purpose: shared constants of the video sync timing control block
// Assumes: included by bare name from the tick divider and sync timing files
// Notes: offsets are the 8-bit subaddresses of the control port
`ifndef VSTC_DEFINES_VH
`define VSTC_DEFINES_VH

// subaddresses
`define VSTC_ADDR_HORIZ_TRIGGER_PHASE_LOW 8'h6c
`define VSTC_ADDR_PHASE_HIGH 8'h6d
`define VSTC_ADDR_BLANK_CTRL 8'h6e
`define VSTC_ADDR_CAPTION_CTRL 8'h6f
`define VSTC_ADDR_REF_START_LOW 8'h70
`define VSTC_ADDR_REF_END_LOW 8'h71
`define VSTC_ADDR_REF_HIGH 8'h72

// reset values
`define VSTC_RST_HORIZ_TRIGGER_PHASE_LOW 8'h00
`define VSTC_RST_PHASE_HIGH 8'h00
`define VSTC_RST_BLANK_CTRL 8'h40
`define VSTC_RST_CAPTION_CTRL 8'h00
`define VSTC_RST_REF_START_LOW 8'h00
`define VSTC_RST_REF_END_LOW 8'h00
`define VSTC_RST_REF_HIGH 8'h00
`define VSTC_REF_HIGH_WMASK 8'h77

// field positions
`define VSTC_HORIZ_TRIGGER_PHASE_HI_MSB 7
`define VSTC_HORIZ_TRIGGER_PHASE_HI_LSB 5
`define VSTC_VERT_TRIGGER_PHASE_MSB 4
`define VSTC_VERT_TRIGGER_PHASE_LSB 0
`define VSTC_STD_VBLANK_BIT 7
`define VSTC_FORCE_BLANK_BIT 6
`define VSTC_SUBCARRIER_PHASE_RESET_MODE_MSB 5
`define VSTC_SUBCARRIER_PHASE_RESET_MODE_LSB 4
`define VSTC_LUMA_DELAY_SEL_MSB 3
`define VSTC_LUMA_DELAY_SEL_LSB 2
`define VSTC_FLC_MSB 1
`define VSTC_FLC_LSB 0
`define VSTC_CAPTION_FIELD_ENABLE_MSB 7
`define VSTC_CAPTION_FIELD_ENABLE_LSB 6
`define VSTC_TELETEXT_INSERT_ENABLE_BIT 5
`define VSTC_CCLN_MSB 4
`define VSTC_CCLN_LSB 0
`define VSTC_REF_START_HI_MSB 2
`define VSTC_REF_START_HI_LSB 0
`define VSTC_REF_END_HI_MSB 6
`define VSTC_REF_END_HI_LSB 4

// pixel divider in clk cycles; other timing counts in pixel clock periods
`define VSTC_PIX_DIV 8'h04
`define VSTC_LINE_LEN_50 11'h6c0
`define VSTC_LINE_LEN_60 11'h6b4
`define VSTC_HSYNC_START 11'h04f
`define VSTC_HSYNC_WIDTH 11'h040
`define VSTC_REF_ALIGN 12'h006

// field lengths in half lines
`define VSTC_FIELD_IL_50 10'h271
`define VSTC_FIELD_IL_60 10'h20d
`define VSTC_FIELD_SHORT_50 10'h270
`define VSTC_FIELD_SHORT_60 10'h20c
`define VSTC_FIELD_LONG_50 10'h272
`define VSTC_FIELD_LONG_60 10'h20e

// standard active lines and caption line offsets
`define VSTC_STD_FIRST_50 9'h017
`define VSTC_STD_LAST_50 9'h136
`define VSTC_STD_FIRST_60 9'h014
`define VSTC_STD_LAST_60 9'h107
`define VSTC_CC_OFS_M 9'h004
`define VSTC_CC_OFS_OTHER 9'h001

// phase reset modes
`define VSTC_SUBCARRIER_PHASE_RESET_MODE_NONE 2'h0
`define VSTC_SUBCARRIER_PHASE_RESET_MODE_TWO_LINES 2'h1
`define VSTC_SUBCARRIER_PHASE_RESET_MODE_EIGHT_FIELDS 2'h2
`define VSTC_SUBCARRIER_PHASE_RESET_MODE_FOUR_FIELDS 2'h3

`endif

/* core/vstc_tick_div.v */
// Purpose: pixel rate enable pulse from the system clock
// Assumes: DIV of two or more
// Notes: tick is one clk cycle wide
`timescale 1ns/1ps
`include "vstc_defines.vh"
module vstc_tick_div #(
	parameter [7:0] DIV = `VSTC_PIX_DIV
) (
	// clock and reset
	input wire clk,
	input wire rst,
	// enable out
	output reg tick
);
	reg [7:0] count_q;

	always @(posedge clk) begin
		if (rst) begin
			count_q <= 8'h00;
			tick <= 1'b0;
		end else begin
			tick <= (count_q == DIV - 8'h01);
			if (count_q == DIV - 8'h01)
				count_q <= 8'h00;
			else
				count_q <= count_q + 8'h01;
		end
	end
endmodule // vstc_tick_div

/* core/vstc_pixel_delay.v */
// Purpose: selectable 0 to 3 pixel delay of one sample stream
// Assumes: pixelEn is a one-cycle enable
// Notes: output stage adds one fixed pixel, matched on the other path
`timescale 1ns/1ps
module vstc_pixel_delay (
	// clock and reset
	input wire clk,
	input wire rst,
	input wire pixelEn,
	// control
	input wire [1:0] delaySel,
	// data
	input wire [7:0] dataIn,
	output reg [7:0] dataOut
);
	reg [7:0] stage1_q;
	reg [7:0] stage2_q;
	reg [7:0] stage3_q;

	always @(posedge clk) begin
		if (rst) begin
			stage1_q <= 8'h00;
			stage2_q <= 8'h00;
			stage3_q <= 8'h00;
			dataOut <= 8'h00;
		end else if (pixelEn) begin
			stage1_q <= dataIn;
			stage2_q <= stage1_q;
			stage3_q <= stage2_q;
			case (delaySel)
				2'h0: dataOut <= dataIn;
				2'h1: dataOut <= stage1_q;
				2'h2: dataOut <= stage2_q;
				default: dataOut <= stage3_q;
			endcase
		end
	end
endmodule // vstc_pixel_delay

/* core/vstc_sync_timing.v */
// Purpose: sync timing control of the video encoder: trigger phase, blanking, field length, caption, ref pulse
// Assumes: host writes subaddressed registers through the plain register port
// Notes: timing counts in pixel periods from a divided enable
// Behaviour
// - 11-bit horizontal trigger code: low byte at 6C, top bits 7:5 of 6D.
// - larger horizontal code shortens delay of all internal timing signals.
// - code 4F puts output hsync leading slope on the trigger edge.
// - 5-bit vertical code in 6D bits 4:0 shifts timing in half lines.
// - vertical blanking select resets 0: programmed lines; 1: standard interval.
// - forced blanking resets 1, holding blanking level; 0 gives normal operation.
// - 2-bit subcarrier phase reset: none/realtime, two lines, eight fields, four fields.
// - 2-bit luma delay of 0 to 3 pixel periods versus chroma, reset zero.
// - field length: interlaced, short non-interlaced, or long non-interlaced fields.
// - caption enable: off, odd field, even field, or both fields.
// - bit 5 of caption register enables teletext insertion, reset cleared.
// - caption line is line select plus 4 for M systems, else plus 1.
// - 11-bit ref pulse start: low byte at 70, top bits at 72.
// - start code 49 aligns ref pulse leading edge with composite sync slope.
// - pin two as output with option 0 drives ref pulse start to end.
// - start top bits in 72 bits 2:0, bit 3 reserved as zero.
`timescale 1ns/1ps
`include "vstc_defines.vh"
module vstc_sync_timing (
	// clock and reset
	input wire clk,
	input wire rst,
	// register port
	input wire regWrEn,
	input wire regRdEn,
	input wire [7:0] regAddr,
	input wire [7:0] regWrData,
	output reg [7:0] regRdData_q,
	// configuration held elsewhere
	input wire fieldRateSel,
	input wire pinTwoOutputEnable,
	input wire compositeBlankOption,
	input wire [8:0] firstActiveLine,
	input wire [8:0] lastActiveLine,
	input wire realtimeControlEnable,
	// pins
	input wire realtimeControlIn,
	input wire syncPinOne,
	input wire syncPinTwoIn,
	output reg syncPinTwoOut_q,
	output reg syncPinTwoOe_q,
	// video path
	input wire [7:0] lumaIn,
	input wire [7:0] chromaIn,
	output wire [7:0] lumaOut,
	output reg [7:0] chromaOut_q,
	// timing outputs
	output reg hSyncOut_q,
	output reg vBlankOut_q,
	output reg blankLevelOut_q,
	output reg oddField_q,
	output reg scPhaseReset_q,
	output reg captionLineActive_q,
	output reg teletextInsertEnable_q
);
	reg [7:0] htrigLow_q;
	reg [7:0] phaseHigh_q;
	reg [7:0] blankCtrl_q;
	reg [7:0] captionCtrl_q;
	reg [7:0] refStartLow_q;
	reg [7:0] refEndLow_q;
	reg [7:0] refHigh_q;
	reg pinOneMeta_q, pinOneSync_q, pinOneLast_q;
	reg pinTwoMeta_q, pinTwoSync_q, pinTwoLast_q;
	reg rtcMeta_q, rtcSync_q, rtcLast_q;
	reg hTrigPend_q, vTrigPend_q;
	reg [10:0] hCount_q;
	reg [9:0] vHalf_q;
	reg [2:0] fieldCnt_q;
	reg horiz_reference_pulse_q;
	reg [7:0] regRdData_d;
	reg [9:0] fieldHalf;
	reg vBlank;
	reg phaseResetNow;
	wire pixelEn;

	wire [10:0] horizTriggerPhase = {phaseHigh_q[`VSTC_HORIZ_TRIGGER_PHASE_HI_MSB:`VSTC_HORIZ_TRIGGER_PHASE_HI_LSB], htrigLow_q};
	wire [4:0] vertTriggerPhase = phaseHigh_q[`VSTC_VERT_TRIGGER_PHASE_MSB:`VSTC_VERT_TRIGGER_PHASE_LSB];
	wire stdVblankForce = blankCtrl_q[`VSTC_STD_VBLANK_BIT];
	wire forceBlankLevel = blankCtrl_q[`VSTC_FORCE_BLANK_BIT];
	wire [1:0] subcarrierPhaseResetMode = blankCtrl_q[`VSTC_SUBCARRIER_PHASE_RESET_MODE_MSB:`VSTC_SUBCARRIER_PHASE_RESET_MODE_LSB];
	wire [1:0] lumaDelaySel = blankCtrl_q[`VSTC_LUMA_DELAY_SEL_MSB:`VSTC_LUMA_DELAY_SEL_LSB];
	wire [1:0] fieldLengthSel = blankCtrl_q[`VSTC_FLC_MSB:`VSTC_FLC_LSB];
	wire [1:0] captionFieldEnable = captionCtrl_q[`VSTC_CAPTION_FIELD_ENABLE_MSB:`VSTC_CAPTION_FIELD_ENABLE_LSB];
	wire [4:0] captionLineSel = captionCtrl_q[`VSTC_CCLN_MSB:`VSTC_CCLN_LSB];
	wire [10:0] refPulseStart = {refHigh_q[`VSTC_REF_START_HI_MSB:`VSTC_REF_START_HI_LSB], refStartLow_q};
	wire [10:0] refPulseEnd = {refHigh_q[`VSTC_REF_END_HI_MSB:`VSTC_REF_END_HI_LSB], refEndLow_q};

	// line geometry; codes beyond the line length are the host's problem
	wire [10:0] lineLen = fieldRateSel ? `VSTC_LINE_LEN_60 : `VSTC_LINE_LEN_50;
	wire [10:0] halfLen = {1'b0, lineLen[10:1]};
	wire [10:0] hNext = (hCount_q == lineLen - 11'h001) ? 11'h000 : hCount_q + 11'h001;

	// trigger edges, held until the next pixel enable
	wire hEdge = pinTwoSync_q & ~pinTwoLast_q & ~pinTwoOutputEnable;
	wire vEdge = pinOneSync_q & ~pinOneLast_q;
	wire rtcEdge = rtcSync_q & ~rtcLast_q;
	wire hTrigNow = pixelEn & (hTrigPend_q | hEdge);
	wire vTrigNow = pixelEn & (vTrigPend_q | vEdge);
	wire halfTick = pixelEn & ~hTrigNow & ((hNext == 11'h000) | (hNext == halfLen));
	wire lineStart = halfTick & (hNext == 11'h000);
	wire fieldWrap = halfTick & ~vTrigNow & (vHalf_q == fieldHalf - 10'h001);
	wire [8:0] lineNum = vHalf_q[9:1] + 9'h001;
	// count value taken at this enable, so pulse edges land with hsync
	wire [10:0] hLoad = hTrigNow ? horizTriggerPhase : hNext;

	// ref pulse edges moved so code 49 lands on the sync slope at 4F
	wire [11:0] startSum = {1'b0, refPulseStart} + `VSTC_REF_ALIGN;
	wire [11:0] endSum = {1'b0, refPulseEnd} + `VSTC_REF_ALIGN;
	wire [11:0] startWrap = startSum - {1'b0, lineLen};
	wire [11:0] endWrap = endSum - {1'b0, lineLen};
	wire [10:0] startPos = (startSum >= {1'b0, lineLen}) ? startWrap[10:0] : startSum[10:0];
	wire [10:0] endPos = (endSum >= {1'b0, lineLen}) ? endWrap[10:0] : endSum[10:0];

	wire [8:0] captionLine = {4'h0, captionLineSel} + (fieldRateSel ? `VSTC_CC_OFS_M : `VSTC_CC_OFS_OTHER);
	wire [10:0] hSyncEnd = `VSTC_HSYNC_START + `VSTC_HSYNC_WIDTH;

	vstc_tick_div #(
		.DIV(`VSTC_PIX_DIV)
	) u_pixDiv (
		.clk(clk),
		.rst(rst),
		.tick(pixelEn)
	);

	vstc_pixel_delay u_lumaDelay (
		.clk(clk),
		.rst(rst),
		.pixelEn(pixelEn),
		.delaySel(lumaDelaySel),
		.dataIn(lumaIn),
		.dataOut(lumaOut)
	);

	// both long-field codes give the same length
	always @* begin
		case (fieldLengthSel)
			2'h0: fieldHalf = fieldRateSel ? `VSTC_FIELD_IL_60 : `VSTC_FIELD_IL_50;
			2'h1: fieldHalf = fieldRateSel ? `VSTC_FIELD_SHORT_60 : `VSTC_FIELD_SHORT_50;
			default: fieldHalf = fieldRateSel ? `VSTC_FIELD_LONG_60 : `VSTC_FIELD_LONG_50;
		endcase
	end

	always @* begin
		if (stdVblankForce) begin
			if (fieldRateSel)
				vBlank = (lineNum < `VSTC_STD_FIRST_60) | (lineNum > `VSTC_STD_LAST_60);
			else
				vBlank = (lineNum < `VSTC_STD_FIRST_50) | (lineNum > `VSTC_STD_LAST_50);
		end else begin
			vBlank = (lineNum < firstActiveLine) | (lineNum > lastActiveLine);
		end
	end

	// two-line mode has no SECAM variant here
	always @* begin
		case (subcarrierPhaseResetMode)
			`VSTC_SUBCARRIER_PHASE_RESET_MODE_NONE: phaseResetNow = rtcEdge & realtimeControlEnable;
			`VSTC_SUBCARRIER_PHASE_RESET_MODE_TWO_LINES: phaseResetNow = lineStart & ~vHalf_q[1];
			`VSTC_SUBCARRIER_PHASE_RESET_MODE_EIGHT_FIELDS: phaseResetNow = fieldWrap & (fieldCnt_q == 3'h7);
			`VSTC_SUBCARRIER_PHASE_RESET_MODE_FOUR_FIELDS: phaseResetNow = fieldWrap & (fieldCnt_q[1:0] == 2'h3);
			default: phaseResetNow = 1'b0;
		endcase
	end

	// reads of unmapped subaddresses return zero
	always @* begin
		case (regAddr)
			`VSTC_ADDR_HORIZ_TRIGGER_PHASE_LOW: regRdData_d = htrigLow_q;
			`VSTC_ADDR_PHASE_HIGH: regRdData_d = phaseHigh_q;
			`VSTC_ADDR_BLANK_CTRL: regRdData_d = blankCtrl_q;
			`VSTC_ADDR_CAPTION_CTRL: regRdData_d = captionCtrl_q;
			`VSTC_ADDR_REF_START_LOW: regRdData_d = refStartLow_q;
			`VSTC_ADDR_REF_END_LOW: regRdData_d = refEndLow_q;
			`VSTC_ADDR_REF_HIGH: regRdData_d = refHigh_q;
			default: regRdData_d = 8'h00;
		endcase
	end

	// register port
	always @(posedge clk) begin
		if (rst) begin
			htrigLow_q <= `VSTC_RST_HORIZ_TRIGGER_PHASE_LOW;
			phaseHigh_q <= `VSTC_RST_PHASE_HIGH;
			blankCtrl_q <= `VSTC_RST_BLANK_CTRL;
			captionCtrl_q <= `VSTC_RST_CAPTION_CTRL;
			refStartLow_q <= `VSTC_RST_REF_START_LOW;
			refEndLow_q <= `VSTC_RST_REF_END_LOW;
			refHigh_q <= `VSTC_RST_REF_HIGH;
			regRdData_q <= 8'h00;
		end else begin
			if (regRdEn)
				regRdData_q <= regRdData_d;
			// unmapped writes fall through and change nothing
			if (regWrEn) begin
				case (regAddr)
					`VSTC_ADDR_HORIZ_TRIGGER_PHASE_LOW: htrigLow_q <= regWrData;
					`VSTC_ADDR_PHASE_HIGH: phaseHigh_q <= regWrData;
					`VSTC_ADDR_BLANK_CTRL: blankCtrl_q <= regWrData;
					`VSTC_ADDR_CAPTION_CTRL: captionCtrl_q <= regWrData;
					`VSTC_ADDR_REF_START_LOW: refStartLow_q <= regWrData;
					`VSTC_ADDR_REF_END_LOW: refEndLow_q <= regWrData;
					`VSTC_ADDR_REF_HIGH: refHigh_q <= regWrData & `VSTC_REF_HIGH_WMASK;
					default: ;
				endcase
			end
		end
	end

	// pin synchronisers; first stage read only by the second
	always @(posedge clk) begin
		if (rst) begin
			pinOneMeta_q <= 1'b0;
			pinOneSync_q <= 1'b0;
			pinOneLast_q <= 1'b0;
			pinTwoMeta_q <= 1'b0;
			pinTwoSync_q <= 1'b0;
			pinTwoLast_q <= 1'b0;
			rtcMeta_q <= 1'b0;
			rtcSync_q <= 1'b0;
			rtcLast_q <= 1'b0;
			hTrigPend_q <= 1'b0;
			vTrigPend_q <= 1'b0;
		end else begin
			// two flops to settle, a third to find the edge
			pinOneMeta_q <= syncPinOne;
			pinOneSync_q <= pinOneMeta_q;
			pinOneLast_q <= pinOneSync_q;
			pinTwoMeta_q <= syncPinTwoIn;
			pinTwoSync_q <= pinTwoMeta_q;
			pinTwoLast_q <= pinTwoSync_q;
			rtcMeta_q <= realtimeControlIn;
			rtcSync_q <= rtcMeta_q;
			rtcLast_q <= rtcSync_q;
			// an edge between pixel enables is kept, not dropped
			hTrigPend_q <= (hTrigPend_q | hEdge) & ~pixelEn;
			vTrigPend_q <= (vTrigPend_q | vEdge) & ~pixelEn;
		end
	end

	// pixel and half-line counters
	always @(posedge clk) begin
		if (rst) begin
			hCount_q <= 11'h000;
			vHalf_q <= 10'h000;
			fieldCnt_q <= 3'h0;
			oddField_q <= 1'b1;
			horiz_reference_pulse_q <= 1'b0;
			chromaOut_q <= 8'h00;
		end else if (pixelEn) begin
			chromaOut_q <= chromaIn;
			// loading the code skips ahead: larger code, earlier events
			if (hTrigNow)
				hCount_q <= horizTriggerPhase;
			else
				hCount_q <= hNext;
			if (vTrigNow)
				vHalf_q <= {5'h00, vertTriggerPhase};
			else if (fieldWrap)
				vHalf_q <= 10'h000;
			else if (halfTick)
				vHalf_q <= vHalf_q + 10'h001;
			if (fieldWrap) begin
				oddField_q <= ~oddField_q;
				fieldCnt_q <= fieldCnt_q + 3'h1;
			end
			if (hLoad == startPos)
				horiz_reference_pulse_q <= 1'b1;
			else if (hLoad == endPos)
				horiz_reference_pulse_q <= 1'b0;
		end
	end

	// registered outputs
	always @(posedge clk) begin
		if (rst) begin
			hSyncOut_q <= 1'b0;
			vBlankOut_q <= 1'b1;
			blankLevelOut_q <= 1'b1;
			scPhaseReset_q <= 1'b0;
			captionLineActive_q <= 1'b0;
			teletextInsertEnable_q <= 1'b0;
			syncPinTwoOut_q <= 1'b0;
			syncPinTwoOe_q <= 1'b0;
		end else begin
			// all outputs are flops, so pins never see decode glitches
			hSyncOut_q <= (hCount_q >= `VSTC_HSYNC_START) & (hCount_q < hSyncEnd);
			vBlankOut_q <= vBlank;
			blankLevelOut_q <= forceBlankLevel | vBlank;
			scPhaseReset_q <= phaseResetNow;
			captionLineActive_q <= (lineNum == captionLine) &
				(oddField_q ? captionFieldEnable[0] : captionFieldEnable[1]);
			teletextInsertEnable_q <= captionCtrl_q[`VSTC_TELETEXT_INSERT_ENABLE_BIT];
			// option 1 removes the pulse during vertical blanking
			syncPinTwoOut_q <= pinTwoOutputEnable & horiz_reference_pulse_q & (~compositeBlankOption | ~vBlank);
			syncPinTwoOe_q <= pinTwoOutputEnable;
		end
	end
endmodule // vstc_sync_timing

/* sim/vstc_sync_sva.sv */
// Purpose: port checks of the sync timing control block
// Assumes: one clk domain, synchronous rst
// Notes: shadows a few registers from observed writes
`timescale 1ns/1ps
module vstc_sync_sva (
	// clock and reset
	input wire clk,
	input wire rst,
	// register port
	input wire regWrEn,
	input wire regRdEn,
	input wire [7:0] regAddr,
	input wire [7:0] regWrData,
	input wire [7:0] regRdData_q,
	// levels and pins
	input wire pinTwoOutputEnable,
	input wire realtimeControlEnable,
	input wire syncPinTwoIn,
	input wire syncPinTwoOut_q,
	// timing outputs
	input wire hSyncOut_q,
	input wire vBlankOut_q,
	input wire blankLevelOut_q,
	input wire scPhaseReset_q,
	input wire captionLineActive_q,
	input wire teletextInsertEnable_q
);
	reg [7:0] htLo_q;
	reg [2:0] htHi_q;
	reg [1:0] phMode_q;
	reg [1:0] cc_q;
	wire [10:0] htCode = {htHi_q, htLo_q};
	wire wr6f = regWrEn && regAddr == 8'h6f;
	wire wd5 = regWrData[5];
	wire wd6 = regWrData[6];
	always @(posedge clk) begin
		if (rst) begin
			htLo_q <= 8'h00;
			htHi_q <= 3'h0;
			phMode_q <= 2'h0;
			cc_q <= 2'h0;
		end else if (regWrEn) begin
			if (regAddr == 8'h6c) htLo_q <= regWrData;
			if (regAddr == 8'h6d) htHi_q <= regWrData[7:5];
			if (regAddr == 8'h6e) phMode_q <= regWrData[5:4];
			if (regAddr == 8'h6f) cc_q <= regWrData[7:6];
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	AST_RD_HOLD: assert property (!$past(regRdEn) |-> $stable(regRdData_q))
		else $error("read data moved without read");
	AST_RD_UNMAPPED: assert property (regRdEn && (regAddr < 8'h6c || regAddr > 8'h72) |=> regRdData_q == 8'h00)
		else $error("unmapped read not zero");
	AST_RD_TRIG_LOW: assert property (regRdEn && regAddr == 8'h6c |=> regRdData_q == $past(htLo_q))
		else $error("trigger low byte read wrong");
	AST_TTX_VALUE: assert property (wr6f |-> ##2 teletextInsertEnable_q == $past(wd5, 2))
		else $error("teletext enable not written");
	AST_HSYNC_MIN: assert property ($rose(hSyncOut_q) |-> hSyncOut_q [*8])
		else $error("hsync pulse too short");
	AST_TRIG_ALIGN: assert property ($rose(syncPinTwoIn) && !pinTwoOutputEnable && htCode == 11'h04f
		|-> ##[3:10] $rose(hSyncOut_q)) else $error("hsync not aligned to trigger");
	AST_FORCE_BLANK: assert property (regWrEn && regAddr == 8'h6e && wd6 |-> ##2 blankLevelOut_q)
		else $error("forced blanking missing");
	AST_VBLANK_BLANK: assert property (vBlankOut_q [*3] |-> blankLevelOut_q)
		else $error("vertical blanking not at blank level");
	AST_SCPR_PULSE: assert property (scPhaseReset_q |=> !scPhaseReset_q)
		else $error("phase reset wider than one clk");
	// mode 00 without realtime enable never resets the subcarrier
	AST_SCPR_QUIET: assert property (phMode_q == 2'h0 && $past(phMode_q) == 2'h0 && !realtimeControlEnable
		&& !$past(realtimeControlEnable) |-> !scPhaseReset_q) else $error("phase reset in quiet mode");
	AST_CAPTION_OFF: assert property (cc_q == 2'h0 && $past(cc_q) == 2'h0 |-> !captionLineActive_q)
		else $error("caption active while off");
	COV_HSYNC: cover property ($rose(hSyncOut_q));
	COV_PHASE_RESET: cover property (scPhaseReset_q);
	COV_REF_PULSE: cover property ($rose(syncPinTwoOut_q) && pinTwoOutputEnable);
endmodule // vstc_sync_sva

/* sim/vstc_sync_source.sv */
// Purpose: external sync source driving both trigger pins
// Assumes: 50 Hz line, 1728 pixels of four clks
// Notes: rising edges active; pins idle low between pulses
`timescale 1ns/1ps
module vstc_sync_source #(
	parameter LINE_CLKS = 6912,
	parameter PULSE_CLKS = 16
) (
	// clock and start
	input wire clk,
	input wire go,
	// trigger pins
	output reg syncOne = 1'b0,
	output reg syncTwo = 1'b0
);
	integer cnt = 0;
	reg first = 1'b1;
	// period kept exact so later triggers reload the phase already running
	always @(posedge clk) begin
		if (go) begin
			cnt <= (cnt == LINE_CLKS - 1) ? 0 : cnt + 1;
			syncTwo <= cnt < PULSE_CLKS;
			syncOne <= first && cnt < PULSE_CLKS;
			if (cnt == PULSE_CLKS) first <= 1'b0;
		end
	end
endmodule // vstc_sync_source

/* sim/vstc_sync_timing_test.sv */
// Purpose: register and timing tests of the sync timing control block
// Assumes: pixel enable every fourth clk, 50 Hz line
// Notes: field wrap is too far off and no assertion checks it, only oddField staying set; caption line timed from the first trigger
`timescale 1ns/1ps
module vstc_sync_timing_test;
	reg clk = 1'b0;
	reg rst = 1'b1;
	reg regWrEn = 1'b0;
	reg regRdEn = 1'b0;
	reg [7:0] regAddr = 8'h00;
	reg [7:0] regWrData = 8'h00;
	reg pinTwoOutputEnable = 1'b0;
	reg realtimeControlEnable = 1'b0;
	reg realtimeControlIn = 1'b0;
	reg [7:0] lumaIn = 8'h00;
	reg [7:0] chromaIn = 8'h00;
	reg srcGo = 1'b0;
	reg [8:0] firstActiveLine = 9'h001;
	reg hsPrev = 1'b0;
	reg [7:0] rv, v;
	wire [7:0] regRdData_q, lumaOut, chromaOut_q;
	wire srcTwo, syncPinOne, syncPinTwoOut_q, syncPinTwoOe_q, hSyncOut_q, vBlankOut_q, blankLevelOut_q;
	wire oddField_q, scPhaseReset_q, captionLineActive_q, teletextInsertEnable_q;
	wire syncPinTwoIn = syncPinTwoOe_q ? syncPinTwoOut_q : srcTwo;
	integer n_mismatch = 0;
	integer compares = 0;
	integer cyc = 0;
	integer i, k, t0, d0, tL, tC, tV;
	integer tCap = -1;
	vstc_sync_timing i_dut (.clk, .rst, .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData_q,
		.fieldRateSel(1'b0), .pinTwoOutputEnable, .compositeBlankOption(1'b0), .firstActiveLine,
		.lastActiveLine(9'h1ff), .realtimeControlEnable, .realtimeControlIn, .syncPinOne, .syncPinTwoIn,
		.syncPinTwoOut_q, .syncPinTwoOe_q, .lumaIn, .chromaIn, .lumaOut, .chromaOut_q, .hSyncOut_q,
		.vBlankOut_q, .blankLevelOut_q, .oddField_q, .scPhaseReset_q, .captionLineActive_q,
		.teletextInsertEnable_q);
	vstc_sync_source i_src (.clk, .go(srcGo), .syncOne(syncPinOne), .syncTwo(srcTwo));
	always #10 clk = ~clk;
	always @(posedge clk) begin
		hsPrev <= hSyncOut_q;
		if (srcGo && tCap < 0 && captionLineActive_q)
			tCap <= cyc;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			n_mismatch = n_mismatch + 1;
			conclude;
		end
	end
	task chk(input string nm, input [15:0] seen, input [15:0] exp);
		compares = compares + 1;
		if (seen !== exp) begin
			n_mismatch = n_mismatch + 1;
			$display("unexpected %0s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task conclude;
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task wr(input [7:0] a, input [7:0] d);
		@(posedge clk);
		regWrEn <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clk);
		regWrEn <= 1'b0;
	endtask
	task rd(input [7:0] a, output [7:0] d);
		@(posedge clk);
		regRdEn <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRdEn <= 1'b0;
		@(posedge clk);
		#1 d = regRdData_q;
	endtask
	task wrc(input [7:0] a, input [7:0] d, input [7:0] e);
		wr(a, d);
		rd(a, rv);
		chk("readback", rv, e);
	endtask
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		#1 chk("blankLevel", blankLevelOut_q, 1'b1);
		for (i = 0; i < 8; i = i + 1) begin
			rd(8'h6c + i[7:0], rv);
			chk("resetValue", rv, (i == 2) ? 8'h40 : 8'h00);
		end
		wrc(8'h6d, 8'hbf, 8'hbf);
		wrc(8'h72, 8'h5d, 8'h55);
		wrc(8'h70, 8'h49, 8'h49);
		wr(8'h80, 8'h5a);
		rd(8'h80, rv);
		chk("unmapped", rv, 8'h00);
		wr(8'h6d, 8'h00);
		wr(8'h72, 8'h00);
		// every mode code of both control registers, luma delay measured per code
		for (i = 0; i < 4; i = i + 1) begin
			v = 8'h40 | (8'h15 * i[1:0]);
			wrc(8'h6e, v, v);
			v = {i[1:0], i[0], 5'h15};
			wrc(8'h6f, v, v);
			chk("teletext", teletextInsertEnable_q, i[0]);
			@(posedge clk);
			lumaIn <= 8'h00;
			chromaIn <= 8'h00;
			repeat (40) @(posedge clk);
			lumaIn <= 8'ha5;
			chromaIn <= 8'ha5;
			tL = -1;
			tC = -1;
			for (k = 0; k < 60; k = k + 1) begin
				@(posedge clk);
				#1;
				if (tL < 0 && lumaOut === 8'ha5) tL = k;
				if (tC < 0 && chromaOut_q === 8'ha5) tC = k;
			end
			chk("lumaDelay", tL - tC, 4 * i);
		end
		wr(8'h6c, 8'h4f);
		wr(8'h6f, 8'hc3);
		// start triggers while hsync is low so the first reload cannot stretch a pulse
		@(negedge hSyncOut_q);
		@(posedge clk);
		srcGo <= 1'b1;
		@(posedge srcTwo);
		#1 t0 = cyc;
		@(posedge hSyncOut_q);
		#1 d0 = cyc - t0;
		tV = t0;
		chk("hsyncAlign", d0 >= 4 && d0 <= 7, 1'b1);
		@(negedge hSyncOut_q);
		#1 chk("hsyncWidth", cyc - t0 - d0, 256);
		wr(8'h6c, 8'h40);
		@(posedge srcTwo);
		#1 t0 = cyc;
		@(posedge hSyncOut_q);
		#1 chk("trigDelay", cyc - t0 - d0, 60);
		wr(8'h6e, 8'h10);
		@(posedge scPhaseReset_q);
		#1 t0 = cyc;
		@(posedge scPhaseReset_q);
		#1 chk("phaseResetGap", cyc - t0, 13824);
		wr(8'h6e, 8'h00);
		realtimeControlEnable <= 1'b1;
		@(posedge clk);
		realtimeControlIn <= 1'b1;
		k = 0;
		repeat (12) begin
			@(posedge clk);
			#1 if (scPhaseReset_q === 1'b1) k = 1;
		end
		chk("rtcReset", k, 1);
		chk("vBlank", vBlankOut_q, 1'b0);
		chk("blankLevel", blankLevelOut_q, 1'b0);
		@(posedge clk);
		realtimeControlIn <= 1'b0;
		realtimeControlEnable <= 1'b0;
		firstActiveLine <= 9'h100;
		repeat (2) @(posedge clk);
		#1 chk("vBlankProg", vBlankOut_q, 1'b1);
		@(posedge clk);
		firstActiveLine <= 9'h001;
		wr(8'h6e, 8'h80);
		repeat (4) @(posedge clk);
		#1 chk("vBlankStd", vBlankOut_q, 1'b1);
		chk("blankLevel", blankLevelOut_q, 1'b1);
		wr(8'h6c, 8'h4f);
		wr(8'h71, 8'h89);
		@(posedge srcTwo);
		@(negedge hSyncOut_q);
		@(posedge clk);
		pinTwoOutputEnable <= 1'b1;
		@(posedge syncPinTwoOut_q);
		#1 chk("refStart", {syncPinTwoOe_q, hSyncOut_q, hsPrev}, 3'b110);
		@(negedge syncPinTwoOut_q);
		#1 chk("refEnd", {hSyncOut_q, hsPrev}, 2'b01);
		chk("captionLine", tCap - tV, d0 + 20480);
		chk("oddField", oddField_q, 1'b1);
		conclude;
	end
endmodule // vstc_sync_timing_test
bind vstc_sync_timing vstc_sync_sva i_sva (.clk, .rst, .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData_q,
	.pinTwoOutputEnable, .realtimeControlEnable, .syncPinTwoIn, .syncPinTwoOut_q, .hSyncOut_q, .vBlankOut_q,
	.blankLevelOut_q, .scPhaseReset_q, .captionLineActive_q, .teletextInsertEnable_q);
